// *** logic/owdl_ctrl.sv ***
// Control and status registers of the one-wire debug link, with error capture,
// time-out, guard time, inter-byte gap, contention check and reset request.
// Assumes the link's instruction decoder drives the register port on mclk_in and
// that the pin sense input is asynchronous.

// Behaviour
// - Registers reachable only through the link's register-access instructions, never the CPU.
// - Read-only revision field in bits 7:4 of the first status register.
// - Error signature loaded on link errors, cleared when the debugger reads it.
// - Codes: parity 0x1, stop bits 0x2, start bit 0x4.
// - Codes: access time-out 0x3, bus fault 0x6, pin contention 0x7; 0x0 none.
// - Control bit 7 inserts two idle bit periods between multi-byte load bytes.
// - Control bit 5 ignores received parity and skips parity errors.
// - Access response needed within 65536 cycles; control bit 4 disables the time-out.
// - Control bit 3 suppresses every response signature.
// - Guard time on RX to TX switch: 128 down to 2 cycles by code.
// - Second control bit 4 suppresses NACK on system reset during load or store.
// - Contention detection active while second control bit 3 is zero.
// - Writing second control bit 2 disables link, drops clock request, clears config, keys.
// - Writing 0x59 to reset request asserts system reset; other value releases it.
// - Prescaler selects 32, 16, 8 or 4 MHz; 4 MHz after reset and enable.
// - System clock request set whenever link is enabled, until debugger clears it.
module owdl_ctrl
   import owdl_pkg::*;
#(
   parameter int TIMEOUT_CYC = OWDL_TIMEOUT_CYC
)
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   input wire owdl_phy_err_t phy_err_in,
   input wire logic acc_wait_in,
   input wire logic acc_resp_in,
   input wire logic pin_sense_in,
   input wire logic pin_drive_oe_in,
   input wire logic pin_drive_val_in,
   input wire logic tx_byte_done_in,
   input wire logic multi_load_in,
   input wire logic bit_tick_in,
   output logic tx_hold_out,
   input wire logic rx_to_tx_in,
   output logic guard_busy_out,
   input wire logic ldst_active_in,
   output logic nack_send_out,
   input wire logic key_erase_in,
   input wire logic key_prog_in,
   input wire logic key_urow_in,
   input wire owdl_sys_t sys_in,
   input wire logic [2:0] crc_status_in,
   input wire logic link_enable_in,
   output owdl_cfg_t cfg_out,
   output logic sys_reset_req_out,
   output logic link_reset_out,
   output logic urow_done_out
);

   owdl_link_t link_state;
   logic [7:0] pctl;
   logic [7:0] dctl;
   logic [7:0] rst_code;
   logic [1:0] prescale;
   logic clk_req;
   logic [2:0] err_sig;
   logic [2:0] keys;
   logic sysrst_flag;
   logic wr_en;
   logic rd_en;
   logic dis_write;
   logic acc_wait_q;
   logic in_reset_q;
   logic [1:0] pin_sync;
   logic [1:0] oe_dly;
   logic [1:0] val_dly;
   logic cont_evt;
   logic tmo_busy;
   logic tmo_done;
   logic new_err;
   logic [2:0] next_err;
   logic [7:0] rd_mux;

   // ==========================================================================
   // Register port decode; writes are dropped while the link is off
   assign wr_en = reg_wr_in && link_state == OWDL_LINK_ON;
   assign rd_en = reg_rd_in && link_state == OWDL_LINK_ON;
   assign dis_write = wr_en && reg_addr_in == OWDL_OFS_DCTL
      && reg_wdata_in[OWDL_DC_LINK_DIS];

   // Link state: off after a disable write, back on when the link is re-enabled
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         link_state <= OWDL_LINK_ON;
      end else begin
         case (link_state)
            OWDL_LINK_ON: if (dis_write) link_state <= OWDL_LINK_OFF;
            OWDL_LINK_OFF: if (link_enable_in) link_state <= OWDL_LINK_ON;
            default: link_state <= OWDL_LINK_ON;
         endcase
      end
   end

   // Reset pulse towards the link's physical layer
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         link_reset_out <= 1'b0;
      end else begin
         link_reset_out <= dis_write;
      end
   end

   // ==========================================================================
   // Protocol and disable controls; a disable write wipes all link configuration
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in || dis_write) begin
         pctl <= OWDL_PCTL_RST;
         dctl <= OWDL_DCTL_RST;
      end else if (wr_en && reg_addr_in == OWDL_OFS_PCTL) begin
         pctl <= {reg_wdata_in[7], 1'b0, reg_wdata_in[5:0]};
      end else if (wr_en && reg_addr_in == OWDL_OFS_DCTL) begin
         dctl <= {3'h0, reg_wdata_in[4:3], 3'h0};
      end
   end

   // Oscillator prescaler returns to the slowest setting on reset and on enable
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in || dis_write || link_enable_in) begin
         prescale <= OWDL_PRESCALE_RST;
      end else if (wr_en && reg_addr_in == OWDL_OFS_CLKSEL) begin
         prescale <= reg_wdata_in[1:0];
      end
   end

   // System clock request: raised by enable, dropped by disable or by the debugger
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in || link_enable_in) begin
         clk_req <= 1'b1;
      end else if (dis_write) begin
         clk_req <= 1'b0;
      end else if (wr_en && reg_addr_in == OWDL_OFS_SYSCTL) begin
         clk_req <= reg_wdata_in[OWDL_SC_CLK_REQ];
      end
   end

   // Reset request holds the system in reset only while the code stands
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in || dis_write) begin
         rst_code <= OWDL_RSTCODE_RST;
      end else if (wr_en && reg_addr_in == OWDL_OFS_RESET) begin
         rst_code <= reg_wdata_in;
      end
   end
   assign sys_reset_req_out = (rst_code == OWDL_RESET_CODE);

   // User row done pulse, accepted only with the user row key decoded
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         urow_done_out <= 1'b0;
      end else begin
         urow_done_out <= wr_en && reg_addr_in == OWDL_OFS_SYSCTL
            && reg_wdata_in[OWDL_SC_UROWDONE] && keys[2];
      end
   end

   // ==========================================================================
   // Key flags {user row, programming, erase}; decode sets win over clears
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in || dis_write) begin
         keys <= 3'h0;
      end else begin
         keys[2] <= key_urow_in || (keys[2] && !(wr_en && reg_addr_in == OWDL_OFS_KEY
            && reg_wdata_in[OWDL_KEY_UROW]));
         keys[1] <= key_prog_in || (keys[1] && !sys_in.prog_ready);
         keys[0] <= key_erase_in || (keys[0] && !sys_reset_req_out);
      end
   end

   // System-reset-seen flag, cleared on read; a reset still active keeps it set
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         sysrst_flag <= 1'b0;
      end else if (sys_in.in_reset) begin
         sysrst_flag <= 1'b1;
      end else if (rd_en && reg_addr_in == OWDL_OFS_SYSST) begin
         sysrst_flag <= 1'b0;
      end
   end

   // ==========================================================================
   // Pin sense passes two flops; drive values are delayed to line up with it
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         pin_sync <= 2'h3;
         oe_dly <= 2'h0;
         val_dly <= 2'h3;
      end else begin
         pin_sync <= {pin_sync[0], pin_sense_in};
         oe_dly <= {oe_dly[0], pin_drive_oe_in};
         val_dly <= {val_dly[0], pin_drive_val_in};
      end
   end
   assign cont_evt = !dctl[OWDL_DC_CONT_OFF] && oe_dly[1] && (pin_sync[1] != val_dly[1]);

   // Access time-out watch, started when the physical layer begins to wait
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         acc_wait_q <= 1'b0;
         in_reset_q <= 1'b0;
      end else begin
         acc_wait_q <= acc_wait_in;
         in_reset_q <= sys_in.in_reset;
      end
   end

   owdl_countdown u_timeout (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .load_in(acc_wait_in && !acc_wait_q && !pctl[OWDL_PC_TMO_OFF]),
      .load_val_in(OWDL_CNT_W'(TIMEOUT_CYC)),
      .step_in(1'b1),
      .abort_in(acc_resp_in || !acc_wait_in || pctl[OWDL_PC_TMO_OFF]),
      .busy_out(tmo_busy),
      .done_out(tmo_done)
   );

   // Guard time before the device turns the line round
   owdl_countdown u_guard (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .load_in(rx_to_tx_in),
      .load_val_in(owdl_guard_cycles(pctl[2:0])),
      .step_in(1'b1),
      .abort_in(dis_write),
      .busy_out(guard_busy_out),
      .done_out()
   );

   // Inter-byte gap counted in bit periods, so it follows the baud rate
   owdl_countdown u_gap (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .load_in(tx_byte_done_in && multi_load_in && pctl[OWDL_PC_GAP]),
      .load_val_in(OWDL_GAP_BITS),
      .step_in(bit_tick_in),
      .abort_in(dis_write),
      .busy_out(tx_hold_out),
      .done_out()
   );

   // ==========================================================================
   // Error priority: contention, bus, time-out, start, stop, parity
   always_comb begin
      new_err = 1'b1;
      if (cont_evt) begin
         next_err = OWDL_E_CONTENTION;
      end else if (phy_err_in.bus) begin
         next_err = OWDL_E_BUS;
      end else if (tmo_done) begin
         next_err = OWDL_E_TIMEOUT;
      end else if (phy_err_in.start) begin
         next_err = OWDL_E_CLKREC;
      end else if (phy_err_in.stop) begin
         next_err = OWDL_E_FRAME;
      end else if (phy_err_in.parity && !pctl[OWDL_PC_PAR_IGN]) begin
         next_err = OWDL_E_PARITY;
      end else begin
         new_err = 1'b0;
         next_err = OWDL_E_NONE;
      end
   end

   // Signature capture: a new error beats the read clear so none is lost
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in || dis_write) begin
         err_sig <= OWDL_E_NONE;
      end else if (new_err) begin
         err_sig <= next_err;
      end else if (rd_en && reg_addr_in == OWDL_OFS_ERR) begin
         err_sig <= OWDL_E_NONE;
      end
   end

   // NACK on a system reset that lands in a load or store
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         nack_send_out <= 1'b0;
      end else begin
         nack_send_out <= sys_in.in_reset && !in_reset_q && ldst_active_in
            && !dctl[OWDL_DC_NACK_OFF];
      end
   end

   // ==========================================================================
   // Read mux; the only way in is this instruction port, no CPU path exists
   always_comb begin
      case (reg_addr_in)
         OWDL_OFS_REV: rd_mux = {OWDL_REVISION, 4'h0};
         OWDL_OFS_ERR: rd_mux = {5'h00, err_sig};
         OWDL_OFS_PCTL: rd_mux = pctl;
         OWDL_OFS_DCTL: rd_mux = dctl;
         OWDL_OFS_KEY: rd_mux = {2'h0, keys, 3'h0};
         OWDL_OFS_RESET: rd_mux = rst_code;
         OWDL_OFS_CLKSEL: rd_mux = {6'h00, prescale};
         OWDL_OFS_SYSCTL: rd_mux = {7'h00, clk_req};
         OWDL_OFS_SYSST: rd_mux = {1'b0, sys_in.erase_failed, sysrst_flag, sys_in.in_sleep,
            sys_in.prog_ready, sys_in.urow_ready, 1'b0, sys_in.locked};
         OWDL_OFS_CRC: rd_mux = {5'h00, crc_status_in};
         default: rd_mux = 8'h00;
      endcase
   end

   // Read data registered; value is the one before any clear-on-read
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= rd_en;
         if (rd_en) begin
            reg_rdata_out <= rd_mux;
         end
      end
   end

   // Configuration seen by the physical layer
   always_comb begin
      cfg_out.gap_en = pctl[OWDL_PC_GAP];
      cfg_out.parity_ignore = pctl[OWDL_PC_PAR_IGN];
      cfg_out.rsp_sig_en = !pctl[OWDL_PC_RSP_OFF];
      cfg_out.contention_en = !dctl[OWDL_DC_CONT_OFF];
      cfg_out.nack_en = !dctl[OWDL_DC_NACK_OFF];
      cfg_out.guard_sel = pctl[2:0];
      cfg_out.prescale = prescale;
      cfg_out.clk_req = clk_req && link_state == OWDL_LINK_ON;
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   chk_err_read_clear: assert property (rd_en && reg_addr_in == OWDL_OFS_ERR && !new_err
      |=> err_sig == OWDL_E_NONE) else $error("error signature not cleared by read");
   chk_rev_read: assert property (rd_en && reg_addr_in == OWDL_OFS_REV
      |=> reg_rvalid_out && reg_rdata_out[7:4] == OWDL_REVISION) else $error("bad revision");
   chk_parity_code: assert property (phy_err_in == 4'b1000 && !cont_evt && !tmo_done
      && !pctl[OWDL_PC_PAR_IGN] && !dis_write |=> err_sig == OWDL_E_PARITY)
      else $error("parity code wrong");
   chk_parity_ignore: assert property (phy_err_in == 4'b1000 && !cont_evt && !tmo_done
      && pctl[OWDL_PC_PAR_IGN] && !rd_en && !dis_write |=> $stable(err_sig))
      else $error("parity error captured while ignored");
   chk_bus_code: assert property (phy_err_in.bus && !cont_evt && !dis_write
      |=> err_sig == OWDL_E_BUS) else $error("bus error code wrong");
   chk_err_hold: assert property (!new_err && !rd_en && !dis_write
      |=> $stable(err_sig)) else $error("error signature changed without cause");
   chk_timeout_code: assert property (tmo_done && !cont_evt && !phy_err_in.bus
      && !dis_write |=> err_sig == OWDL_E_TIMEOUT) else $error("time-out not reported");
   chk_timeout_off: assert property (pctl[OWDL_PC_TMO_OFF] |=> !tmo_busy)
      else $error("time-out running while disabled");
   chk_gap_start: assert property (tx_byte_done_in && multi_load_in && pctl[OWDL_PC_GAP]
      |=> tx_hold_out) else $error("inter-byte gap missing");
   chk_guard_len: assert property (rx_to_tx_in && pctl[2:0] == 3'h6 ##1 !rx_to_tx_in
      ##1 !rx_to_tx_in |-> guard_busy_out ##1 !guard_busy_out) else $error("guard not 2 cycles");
   chk_rsp_sig: assert property (wr_en && reg_addr_in == OWDL_OFS_PCTL && !dis_write
      |=> cfg_out.rsp_sig_en == !$past(reg_wdata_in[OWDL_PC_RSP_OFF]))
      else $error("response signature control wrong");
   chk_nack_off: assert property (nack_send_out |-> $past(!dctl[OWDL_DC_NACK_OFF]
      && ldst_active_in)) else $error("NACK sent while suppressed");
   chk_contention_off: assert property (dctl[OWDL_DC_CONT_OFF] && !dis_write
      |=> err_sig != OWDL_E_CONTENTION || $stable(err_sig))
      else $error("contention detected while disabled");
   chk_link_disable: assert property (dis_write |=> link_reset_out && !cfg_out.clk_req
      && err_sig == OWDL_E_NONE && keys == 3'h0 && pctl == OWDL_PCTL_RST)
      else $error("link disable incomplete");
   chk_reset_code: assert property (wr_en && reg_addr_in == OWDL_OFS_RESET && !dis_write
      |=> sys_reset_req_out == ($past(reg_wdata_in) == OWDL_RESET_CODE))
      else $error("reset request mismatch");
   chk_enable_dflt: assert property (link_enable_in |=> prescale == OWDL_PRESCALE_RST
      && clk_req) else $error("enable defaults wrong");

   cov_err_read: cover property (new_err ##1 rd_en && reg_addr_in == OWDL_OFS_ERR);
   cov_timeout: cover property (tmo_done);
   cov_disable_enable: cover property (dis_write ##[1:20] link_enable_in);
   cov_reset_nack: cover property (nack_send_out);

endmodule : owdl_ctrl

// *** include/owdl_pkg.sv ***
// Constants, field layouts and carrier types of the one-wire debug link control block.
// Assumes one clock for the whole block and a register port driven by the link's
// instruction decoder on that same clock.
package owdl_pkg;

   // ==========================================================================
   // Register offsets (4-bit address from the link's register-access instructions)
   localparam logic [3:0] OWDL_OFS_REV = 4'h0;
   localparam logic [3:0] OWDL_OFS_ERR = 4'h1;
   localparam logic [3:0] OWDL_OFS_PCTL = 4'h2;
   localparam logic [3:0] OWDL_OFS_DCTL = 4'h3;
   localparam logic [3:0] OWDL_OFS_KEY = 4'h7;
   localparam logic [3:0] OWDL_OFS_RESET = 4'h8;
   localparam logic [3:0] OWDL_OFS_CLKSEL = 4'h9;
   localparam logic [3:0] OWDL_OFS_SYSCTL = 4'ha;
   localparam logic [3:0] OWDL_OFS_SYSST = 4'hb;
   localparam logic [3:0] OWDL_OFS_CRC = 4'hc;

   // ==========================================================================
   // Field positions
   localparam int OWDL_PC_GAP = 7;
   localparam int OWDL_PC_PAR_IGN = 5;
   localparam int OWDL_PC_TMO_OFF = 4;
   localparam int OWDL_PC_RSP_OFF = 3;
   localparam int OWDL_DC_NACK_OFF = 4;
   localparam int OWDL_DC_CONT_OFF = 3;
   localparam int OWDL_DC_LINK_DIS = 2;
   localparam int OWDL_KEY_UROW = 5;
   localparam int OWDL_KEY_PROG = 4;
   localparam int OWDL_KEY_ERASE = 3;
   localparam int OWDL_SC_UROWDONE = 1;
   localparam int OWDL_SC_CLK_REQ = 0;

   // ==========================================================================
   // Reset values and codes
   localparam logic [7:0] OWDL_PCTL_RST = 8'h00;
   localparam logic [7:0] OWDL_DCTL_RST = 8'h00;
   localparam logic [7:0] OWDL_RSTCODE_RST = 8'h00;
   localparam logic [7:0] OWDL_RESET_CODE = 8'h59;
   localparam logic [1:0] OWDL_PRESCALE_RST = 2'h3;
   localparam logic [3:0] OWDL_REVISION = 4'h3; // Arbitrary value
   localparam logic [2:0] OWDL_E_NONE = 3'h0;
   localparam logic [2:0] OWDL_E_PARITY = 3'h1;
   localparam logic [2:0] OWDL_E_FRAME = 3'h2;
   localparam logic [2:0] OWDL_E_TIMEOUT = 3'h3;
   localparam logic [2:0] OWDL_E_CLKREC = 3'h4;
   localparam logic [2:0] OWDL_E_BUS = 3'h6;
   localparam logic [2:0] OWDL_E_CONTENTION = 3'h7;

   // ==========================================================================
   // Cycle counts
   localparam int OWDL_CNT_W = 17;
   localparam int OWDL_TIMEOUT_CYC = 65536;
   localparam logic [OWDL_CNT_W-1:0] OWDL_GAP_BITS = 17'h00002;
   localparam logic [OWDL_CNT_W-1:0] OWDL_GUARD_MAX = 17'h00080;

   // Guard time in cycles: 128 halving per step; the reserved code acts as 128
   function automatic logic [OWDL_CNT_W-1:0] owdl_guard_cycles(input logic [2:0] sel);
      logic [OWDL_CNT_W-1:0] cyc;
      cyc = (sel == 3'h7) ? OWDL_GUARD_MAX : (OWDL_GUARD_MAX >> sel);
      return cyc;
   endfunction : owdl_guard_cycles

   // ==========================================================================
   // Carrier types
   typedef struct packed {
      logic parity;
      logic stop;
      logic start;
      logic bus;
   } owdl_phy_err_t;

   typedef struct packed {
      logic gap_en;
      logic parity_ignore;
      logic rsp_sig_en;
      logic contention_en;
      logic nack_en;
      logic [2:0] guard_sel;
      logic [1:0] prescale;
      logic clk_req;
   } owdl_cfg_t;

   typedef struct packed {
      logic erase_failed;
      logic in_reset;
      logic in_sleep;
      logic prog_ready;
      logic urow_ready;
      logic locked;
   } owdl_sys_t;

   typedef enum logic {OWDL_LINK_ON = 1'b0, OWDL_LINK_OFF = 1'b1} owdl_link_t;

endpackage : owdl_pkg

// *** logic/owdl_countdown.sv ***
// Loadable down-counter used for the access time-out, guard time and inter-byte gap.
// Assumes load, abort and step come from logic on the same clock.
module owdl_countdown
   import owdl_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic load_in,
   input wire logic [OWDL_CNT_W-1:0] load_val_in,
   input wire logic step_in,
   input wire logic abort_in,
   output logic busy_out,
   output logic done_out
);

   logic [OWDL_CNT_W-1:0] cnt;

   // ==========================================================================
   // Counter; a load beats an abort so a restart in the same cycle is kept
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         cnt <= '0;
      end else if (load_in) begin
         cnt <= load_val_in;
      end else if (abort_in) begin
         cnt <= '0;
      end else if (step_in && cnt != '0) begin
         cnt <= cnt - 17'h00001;
      end
   end

   // Pulse on the step that empties the counter
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= step_in && cnt == 17'h00001 && !load_in && !abort_in;
      end
   end

   assign busy_out = (cnt != '0);

endmodule : owdl_countdown

// *** verif/owdl_dbg_model.sv ***
// Debugger-side model: register reads and writes through the link's access instructions.
// Assumes one clock; strobes and data change only on the falling edge.
module owdl_dbg_model
   import owdl_pkg::*;
(
   input wire logic mclk_in,
   output logic [3:0] reg_addr_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [7:0] reg_wdata_out,
   input wire logic [7:0] reg_rdata_in,
   input wire logic reg_rvalid_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // Signatures stay enabled, since bus delays are not predictable
   localparam logic [7:0] SIG_KEEP = 8'h00;
   initial begin
      reg_addr_out = 4'h0;
      reg_wr_out = 1'h0;
      reg_rd_out = 1'h0;
      reg_wdata_out = SIG_KEEP;
   end
   // Write: one-cycle strobe; data is inverted after release so stale data never matches
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(negedge mclk_in);
      reg_addr_out = a;
      reg_wdata_out = v;
      reg_wr_out = 1'h1;
      @(negedge mclk_in);
      reg_wr_out = 1'h0;
      reg_wdata_out = ~v;
   endtask : wr
   // Read: answer is sampled while the one-cycle valid stands
   task automatic rd(input logic [3:0] a, output logic [7:0] v, output logic ok);
      @(negedge mclk_in);
      reg_addr_out = a;
      reg_rd_out = 1'h1;
      @(negedge mclk_in);
      ok = reg_rvalid_in;
      v = reg_rdata_in;
      reg_rd_out = 1'h0;
   endtask : rd
endmodule : owdl_dbg_model

// *** verif/test_owdl_ctrl.sv ***
// Bench for the debug link control block: register accesses through the debugger model.
// Assumes the access time-out is shortened to 16 cycles; inputs change on falling edges.
module test_owdl_ctrl
   import owdl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_in = 1'h0;
   logic sys_rst_in = 1'h1;
   logic [3:0] addr;
   logic wr, rd, rvalid, ok, hold, gbusy, nack, sysrst;
   logic [7:0] wdata, rdata, d;
   owdl_phy_err_t phy_err = '0;
   owdl_sys_t sys = '0;
   owdl_cfg_t cfg;
   logic acc_wait = 1'h0, oe = 1'h0, pval = 1'h0, psense = 1'h0, tx_done = 1'h0;
   logic mload = 1'h0, tick = 1'h0, rx2tx = 1'h0, ldst = 1'h0, kprog = 1'h0, link_en = 1'h0;
   logic [7:0] codes [4] = '{8'h01, 8'h02, 8'h04, 8'h06};
   int fail_count = 0, cmp_count = 0, n;
   // ==========================================================
   // Clock, partner and design
   always #2.5 mclk_in = ~mclk_in;
   owdl_dbg_model u_dbg (.mclk_in(mclk_in), .reg_addr_out(addr), .reg_wr_out(wr),
      .reg_rd_out(rd), .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));
   owdl_ctrl #(.TIMEOUT_CYC(16)) u_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .phy_err_in(phy_err),
      .acc_wait_in(acc_wait), .acc_resp_in(1'h0), .pin_sense_in(psense),
      .pin_drive_oe_in(oe), .pin_drive_val_in(pval), .tx_byte_done_in(tx_done),
      .multi_load_in(mload), .bit_tick_in(tick), .tx_hold_out(hold), .rx_to_tx_in(rx2tx),
      .guard_busy_out(gbusy), .ldst_active_in(ldst), .nack_send_out(nack),
      .key_erase_in(1'h0), .key_prog_in(kprog), .key_urow_in(1'h0), .sys_in(sys),
      .crc_status_in(3'h5), .link_enable_in(link_en), .cfg_out(cfg),
      .sys_reset_req_out(sysrst), .link_reset_out(), .urow_done_out());
   // ==========================================================
   // Compare and closing
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      u_dbg.rd(a, d, ok);
      chk({7'h0, ok}, 8'h01);
      chk(d, exp);
   endtask : rdchk
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   // Watchdog: the whole sequence needs well under 5000 cycles
   initial begin
      #100000;
      fail_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_sim();
   end
   // ==========================================================
   // Test sequence
   initial begin
      repeat (12) @(negedge mclk_in);
      sys_rst_in = 1'h0;
      u_dbg.wr(OWDL_OFS_REV, 8'hff);
      rdchk(OWDL_OFS_REV, {OWDL_REVISION, 4'h0});
      rdchk(OWDL_OFS_PCTL, 8'h00);
      rdchk(4'h5, 8'h00);
      rdchk(OWDL_OFS_CLKSEL, 8'h03);
      rdchk(OWDL_OFS_SYSCTL, 8'h01);
      rdchk(OWDL_OFS_CRC, 8'h05);
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         phy_err = 4'h8 >> i;
         @(negedge mclk_in);
         phy_err = '0;
         rdchk(OWDL_OFS_ERR, codes[i]);
         rdchk(OWDL_OFS_ERR, 8'h00);
      end
      phy_err = 4'h8;
      @(negedge mclk_in);
      phy_err = 4'h4;
      @(negedge mclk_in);
      phy_err = '0;
      rdchk(OWDL_OFS_ERR, 8'h02);
      for (int t = 0; t < 2; t++) begin
         u_dbg.wr(OWDL_OFS_PCTL, t ? 8'h10 : 8'h00);
         acc_wait = 1'h1;
         repeat (20) @(negedge mclk_in);
         acc_wait = 1'h0;
         rdchk(OWDL_OFS_ERR, t ? 8'h00 : 8'h03);
      end
      $display("test error signatures done");
      for (int s = 0; s < 8; s++) begin
         u_dbg.wr(OWDL_OFS_PCTL, 8'(s));
         rx2tx = 1'h1;
         @(negedge mclk_in);
         rx2tx = 1'h0;
         n = 0;
         while (gbusy === 1'h1 && n < 300) begin
            n++;
            @(negedge mclk_in);
         end
         chk(8'(n), (s == 7) ? 8'h80 : 8'h80 >> s);
      end
      u_dbg.wr(OWDL_OFS_PCTL, 8'ha8);
      chk({5'h0, cfg.gap_en, cfg.parity_ignore, cfg.rsp_sig_en}, 8'h06);
      // A parity error must leave no signature while parity is ignored
      phy_err = 4'h8;
      @(negedge mclk_in);
      phy_err = '0;
      rdchk(OWDL_OFS_ERR, 8'h00);
      mload = 1'h1;
      tx_done = 1'h1;
      @(negedge mclk_in);
      tx_done = 1'h0;
      chk({7'h0, hold}, 8'h01);
      repeat (2) begin
         tick = 1'h1;
         @(negedge mclk_in);
         tick = 1'h0;
         @(negedge mclk_in);
      end
      @(negedge mclk_in);
      chk({7'h0, hold}, 8'h00);
      $display("test protocol options done");
      for (int t = 0; t < 2; t++) begin
         u_dbg.wr(OWDL_OFS_DCTL, t ? 8'h08 : 8'h00);
         psense = 1'h0;
         oe = 1'h1;
         pval = 1'h1;
         repeat (4) @(negedge mclk_in);
         psense = 1'h1;
         repeat (4) @(negedge mclk_in);
         oe = 1'h0;
         rdchk(OWDL_OFS_ERR, t ? 8'h00 : 8'h07);
      end
      for (int t = 0; t < 2; t++) begin
         u_dbg.wr(OWDL_OFS_DCTL, t ? 8'h10 : 8'h00);
         ldst = 1'h1;
         sys.in_reset = 1'h1;
         @(negedge mclk_in);
         chk({7'h0, nack}, t ? 8'h00 : 8'h01);
         sys.in_reset = 1'h0;
      end
      u_dbg.wr(OWDL_OFS_RESET, OWDL_RESET_CODE);
      chk({7'h0, sysrst}, 8'h01);
      u_dbg.wr(OWDL_OFS_RESET, 8'h5a);
      chk({7'h0, sysrst}, 8'h00);
      $display("test contention, nack and reset request done");
      kprog = 1'h1;
      @(negedge mclk_in);
      kprog = 1'h0;
      rdchk(OWDL_OFS_KEY, 8'h10);
      u_dbg.wr(OWDL_OFS_DCTL, 8'h04);
      chk({7'h0, cfg.clk_req}, 8'h00);
      link_en = 1'h1;
      @(negedge mclk_in);
      link_en = 1'h0;
      @(negedge mclk_in);
      chk({5'h0, cfg.clk_req, cfg.prescale}, 8'h07);
      rdchk(OWDL_OFS_KEY, 8'h00);
      rdchk(OWDL_OFS_PCTL, 8'h00);
      $display("test link disable done");
      end_sim();
   end
endmodule : test_owdl_ctrl
